// ===== common/cstx_consts.vh
// Purpose: Offsets, field positions, reset values and timing counts for the transmit calibration block.
// Assumes: Byte-wide register port addressed by 8-bit register offsets.
// Notes: Definitions only.
`ifndef CSTX_CONSTS_VH
`define CSTX_CONSTS_VH

`define CSTX_ADDR_PORT_SELECT 8'h32
`define CSTX_ADDR_CAL_CONTROL 8'h34
`define CSTX_ADDR_PORT_STATUS 8'h35

`define CSTX_CAL_CONTROL_RESET 8'h00
`define CSTX_PORT_STATUS_RESET 8'h00
`define CSTX_PORT_SELECT_RESET 8'h00

`define CSTX_BIT_PERIODIC 0
`define CSTX_BIT_SINGLE 1
`define CSTX_BIT_INVERT 2
`define CSTX_BIT_PASS_MODE 3
`define CSTX_LEN_LSB 4
`define CSTX_LEN_MSB 5
`define CSTX_CAL_CONTROL_MASK 8'h3F

`define CSTX_BIT_STS_PASS 0
`define CSTX_BIT_STS_SYNC 1
`define CSTX_BIT_STS_PORT 4

`define CSTX_BIT_SEL_WRITE 0
`define CSTX_PORT_SELECT_MASK 8'h01

`define CSTX_LEN_BITS_00 17'h00400
`define CSTX_LEN_BITS_01 17'h01000
`define CSTX_LEN_BITS_10 17'h04000
`define CSTX_LEN_BITS_11 17'h08000

`endif

// ===== logic/cstx_sync2.v
// Purpose: Two-flop synchroniser for levels arriving from outside the clock domain.
// Assumes: Input is a level or a slow clock sampled by clk_i.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/100ps
`default_nettype none
module cstx_sync2 #(
  parameter WIDTH = 1
) (
  input wire clk_i,              // System clock.
  input wire reset_i,            // Synchronous reset, active high.
  input wire [WIDTH-1:0] async_i, // Asynchronous levels.
  output reg [WIDTH-1:0] sync_o   // Synchronised levels.
);
  reg [WIDTH-1:0] meta;

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      meta <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== logic/cstx_calibration_status.v
// Purpose: Skew-calibration control and transmit-port status registers of the serial camera output.
// Assumes: Register port is a byte-wide strobe interface behind the I2C target; link clock sampled by clk_i.
// Notes: The calibration pattern is emitted one bit per rising edge of the sampled link clock.
// Functional notes
// - The length code 00, 01, 10, 11 selects a calibration sequence of 2^10, 2^12, 2^14 or 2^15 bits.
// - Pass mode 0 asserts pass if any enabled receive port has valid video, mode 1 only if all of them do.
// - The calibration pattern alternates starting with 0, and the invert bit makes it start with 1.
// - Writing 1 to the single bit requests one sequence and the bit clears itself once it is sent.
// - A single sequence waits for the next idle period of the serial output, never splitting a packet.
// - A single sequence has the same length as the periodic length setting.
// - With periodic enable set a sequence follows every Frame End packet, with it clear none is sent.
// - A read-only status bit reports the transmit port number, fixed at 0 for the only transmit port.
// - The synchronized status bit reads 0 while stream synchronization is disabled.
// - In asynchronous forwarding the pass bit shows that valid video is actively being delivered.
// - In asynchronous forwarding the pass bit clears when a transmission-stopping error is seen.
// - In synchronized forwarding the pass bit shows only that valid data is available for output.
// - Register writes to these transmit registers land only when the port-select register chooses this port; reads are not gated.
// - With initial calibration enabled a sequence is sent at initialization before any high-speed data.
`timescale 1ns/100ps
`default_nettype none
`include "cstx_consts.vh"
module cstx_calibration_status #(
  parameter RX_PORTS = 4
) (
  input wire clk_i,                    // 20 MHz system clock.
  input wire reset_i,                  // Synchronous reset, active high.
  input wire reg_wr_i,                 // Register write strobe, one cycle.
  input wire reg_rd_i,                 // Register read strobe, one cycle.
  input wire [7:0] reg_addr_i,         // Register offset.
  input wire [7:0] reg_wdata_i,        // Write data.
  output reg [7:0] reg_rdata_o,        // Read data, valid the cycle after reg_rd_i.
  output reg reg_rvalid_o,             // Read data valid pulse.
  input wire link_clk_i,               // Serial output bit clock, sampled.
  input wire tx_idle_i,                // Serial output is between packets.
  input wire frame_end_sent_i,         // One-cycle pulse when a Frame End packet has gone out.
  input wire tx_init_i,                // Transmitter initialization pulse.
  input wire initial_cal_enable_i,     // Initial calibration enable from the control register.
  input wire [RX_PORTS-1:0] rx_enabled_i, // Receive ports enabled for forwarding.
  input wire [RX_PORTS-1:0] rx_valid_i,   // Receive ports supplying valid video.
  input wire sync_forwarding_i,        // Synchronized forwarding selected.
  input wire streams_synced_i,         // Merged input streams are aligned.
  input wire tx_error_i,               // Error that interrupts transmission.
  output reg cal_active_o,             // Calibration sequence in progress.
  output reg cal_data_o,               // Calibration pattern bit.
  output reg hs_data_allowed_o         // High-speed data may be sent.
);
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_SEND = 2'b10;

  reg [7:0] cal_control;
  reg [7:0] port_select;
  reg [1:0] state;
  reg [16:0] bit_count;
  reg link_prev;
  reg single_pending;
  reg periodic_pending;
  reg init_pending;
  reg cal_is_single;
  reg pass_state;
  reg sync_state;
  wire link_clk_s;
  wire [2:0] sync_levels;
  wire [RX_PORTS-1:0] valid_on_enabled;
  wire link_rise;
  wire any_valid;
  wire all_valid;
  wire pass_raw;
  wire wr_cal;
  wire wr_sel;
  wire seq_last;
  wire [16:0] len_bits;
  wire [RX_PORTS-1:0] valid_and_enabled;
  wire [7:0] status_word;
  // This block serves the only transmit port, so the reported port number is fixed at 0.
  localparam [0:0] TX_PORT_NUMBER = 1'b0;

  // The link clock, idle and stream-sync levels are synchronised before use.
  cstx_sync2 #(.WIDTH(3)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({link_clk_i, tx_idle_i, streams_synced_i}),
    .sync_o(sync_levels)
  );
  assign link_clk_s = sync_levels[2];

  function [16:0] len_decode;
    input [1:0] code;
    begin
      case (code)
        2'b00: len_decode = `CSTX_LEN_BITS_00;
        2'b01: len_decode = `CSTX_LEN_BITS_01;
        2'b10: len_decode = `CSTX_LEN_BITS_10;
        default: len_decode = `CSTX_LEN_BITS_11;
      endcase
    end
  endfunction

  assign link_rise = link_clk_s & ~link_prev;
  // Each receive port is qualified by its own enable before the pass vote.
  genvar idx;
  generate
    for (idx = 0; idx < RX_PORTS; idx = idx + 1)
    begin : g_port
      assign valid_on_enabled[idx] = rx_valid_i[idx] | ~rx_enabled_i[idx];
      assign valid_and_enabled[idx] = rx_valid_i[idx] & rx_enabled_i[idx];
    end
  endgenerate
  assign any_valid = |valid_and_enabled;
  assign all_valid = (&valid_on_enabled) & (|rx_enabled_i);
  assign pass_raw = cal_control[`CSTX_BIT_PASS_MODE] ? all_valid : any_valid;
  // Control-register writes only land when the write-enable bit selects this single transmit port.
  assign wr_cal = reg_wr_i & (reg_addr_i == `CSTX_ADDR_CAL_CONTROL) & port_select[`CSTX_BIT_SEL_WRITE];
  assign wr_sel = reg_wr_i & (reg_addr_i == `CSTX_ADDR_PORT_SELECT);
  // The last bit of a sequence is the link edge that retires the count.
  assign seq_last = (state == ST_SEND) & link_rise & (bit_count == 17'h00001);
  assign len_bits = len_decode(cal_control[`CSTX_LEN_MSB:`CSTX_LEN_LSB]);
  assign status_word = {3'b000, TX_PORT_NUMBER, 2'b00, sync_state, pass_state};

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      link_prev <= 1'b0;
    end
    else
    begin
      link_prev <= link_clk_s;
    end
  end

  // Port select and the control register.
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      port_select <= `CSTX_PORT_SELECT_RESET;
      cal_control <= `CSTX_CAL_CONTROL_RESET;
    end
    else
    begin
      if (wr_sel)
      begin
        port_select <= reg_wdata_i & `CSTX_PORT_SELECT_MASK;
      end
      if (wr_cal)
      begin
        cal_control <= reg_wdata_i & `CSTX_CAL_CONTROL_MASK;
      end
      // A fresh write of 1 wins over the self-clear in the same cycle.
      if (seq_last && cal_is_single && !(wr_cal && reg_wdata_i[`CSTX_BIT_SINGLE]))
      begin
        cal_control[`CSTX_BIT_SINGLE] <= 1'b0;
      end
    end
  end

  // Read port: one cycle latency.
  // Offsets that belong to no register here read as zero rather than holding stale data.
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          `CSTX_ADDR_PORT_SELECT: reg_rdata_o <= port_select;
          `CSTX_ADDR_CAL_CONTROL: reg_rdata_o <= cal_control;
          `CSTX_ADDR_PORT_STATUS: reg_rdata_o <= status_word;
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // Status bits.
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pass_state <= 1'b0;
      sync_state <= 1'b0;
    end
    else
    begin
      sync_state <= sync_forwarding_i & sync_levels[0];
      if (sync_forwarding_i)
      begin
        pass_state <= pass_raw;
      end
      else if (tx_error_i)
      begin
        pass_state <= 1'b0;
      end
      else
      begin
        pass_state <= pass_raw & hs_data_allowed_o;
      end
    end
  end

  // Calibration sequencer.
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state <= ST_IDLE;
      bit_count <= 17'h00000;
      single_pending <= 1'b0;
      periodic_pending <= 1'b0;
      init_pending <= 1'b0;
      cal_is_single <= 1'b0;
      cal_active_o <= 1'b0;
      cal_data_o <= 1'b0;
      hs_data_allowed_o <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          cal_active_o <= 1'b0;
          if (single_pending || periodic_pending || init_pending)
          begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          // Waiting for idle keeps a sequence from splitting a packet.
          if (sync_levels[1])
          begin
            state <= ST_SEND;
            bit_count <= len_bits;
            cal_is_single <= single_pending & ~periodic_pending & ~init_pending;
            if (periodic_pending)
            begin
              periodic_pending <= 1'b0;
            end
            else if (init_pending)
            begin
              init_pending <= 1'b0;
            end
            else
            begin
              single_pending <= 1'b0;
            end
            cal_active_o <= 1'b1;
            cal_data_o <= cal_control[`CSTX_BIT_INVERT];
          end
        end
        ST_SEND:
        begin
          if (link_rise)
          begin
            // The pattern toggles per bit, so its phase is set by the first bit.
            cal_data_o <= ~cal_data_o;
            bit_count <= bit_count - 17'h00001;
            if (seq_last)
            begin
              state <= ST_IDLE;
              cal_active_o <= 1'b0;
              cal_data_o <= 1'b0;
              // A pending initial sequence still holds high-speed data back.
              if (!init_pending)
              begin
                hs_data_allowed_o <= 1'b1;
              end
            end
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
      // Requests are recorded after the sequencer so a new request wins over a clear in the same cycle.
      if (wr_cal && reg_wdata_i[`CSTX_BIT_SINGLE])
      begin
        single_pending <= 1'b1;
      end
      if (frame_end_sent_i && cal_control[`CSTX_BIT_PERIODIC])
      begin
        periodic_pending <= 1'b1;
      end
      if (tx_init_i)
      begin
        init_pending <= initial_cal_enable_i;
        hs_data_allowed_o <= ~initial_cal_enable_i;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/cstx_assertions.sv
// Purpose: Port-level checks of the calibration and status block.
// Assumes: Several system cycles per link bit.
// Notes: Bound into every instance of the block.
`timescale 1ns/100ps
`default_nettype none
module cstx_assertions (
  input wire logic clk_i, // Clock.
  input wire logic reset_i, // Reset.
  input wire logic reg_rd_i, // Read strobe.
  input wire logic [7:0] reg_addr_i, // Offset.
  input wire logic [7:0] reg_rdata_o, // Read data.
  input wire logic reg_rvalid_o, // Read valid.
  input wire logic tx_idle_i, // Idle.
  input wire logic tx_init_i, // Init pulse.
  input wire logic initial_cal_enable_i, // Init enable.
  input wire logic sync_forwarding_i, // Sync mode.
  input wire logic tx_error_i, // Error.
  input wire logic cal_active_o, // Sequence on.
  input wire logic cal_data_o, // Pattern bit.
  input wire logic hs_data_allowed_o // HS allowed.
);
  logic [19:0] act_cnt;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Length is counted in system cycles, so the link sampling jitter makes the bounds loose.
  always @(posedge clk_i)
  begin
    if (reset_i || !cal_active_o)
      act_cnt <= 20'h00000;
    else
      act_cnt <= act_cnt + 20'h00001;
  end
  read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  status_reserved_a: assert property (reg_rd_i && reg_addr_i == 8'h35 |=> reg_rdata_o[7:2] == 6'h00)
    else $error("status reserved bits set");
  sync_off_a: assert property ((!sync_forwarding_i) [*4] ##0 (reg_rd_i && reg_addr_i == 8'h35)
    |=> !reg_rdata_o[1]) else $error("sync set while disabled");
  error_clears_a: assert property ((tx_error_i && !sync_forwarding_i) [*4] ##0 (reg_rd_i && reg_addr_i == 8'h35)
    |=> !reg_rdata_o[0]) else $error("pass set during error");
  init_holds_a: assert property (tx_init_i && initial_cal_enable_i |=> !hs_data_allowed_o)
    else $error("data allowed before initial sequence");
  start_idle_a: assert property ($rose(cal_active_o) |-> $past(tx_idle_i, 3))
    else $error("sequence started outside idle");
  bit_spacing_a: assert property (cal_active_o && $past(cal_active_o) && $changed(cal_data_o)
    |=> ($stable(cal_data_o) || !cal_active_o) [*6]) else $error("pattern bit faster than link");
  seq_length_a: assert property ($fell(cal_active_o) |-> act_cnt >= 20'h01FF0 && act_cnt <= 20'h40040)
    else $error("sequence length out of range");
endmodule
bind cstx_calibration_status cstx_assertions cstx_assertions_i (.clk_i, .reset_i, .reg_rd_i, .reg_addr_i,
  .reg_rdata_o, .reg_rvalid_o, .tx_idle_i, .tx_init_i, .initial_cal_enable_i, .sync_forwarding_i, .tx_error_i,
  .cal_active_o, .cal_data_o, .hs_data_allowed_o);
`default_nettype wire

// ===== tb/cstx_link_model.sv
// Purpose: Downstream receiver model that makes the link clock and measures calibration sequences.
// Assumes: Pattern bits change only while cal_active_i is high.
// Notes: The link clock is offset so its edges never meet the system clock edges.
`timescale 1ns/100ps
`default_nettype none
module cstx_link_model (
  input wire logic clk_i, // Clock.
  input wire logic cal_active_i, // Sequence on.
  input wire logic cal_data_i, // Pattern bit.
  output logic link_clk_o, // Bit clock.
  output logic [16:0] bits_o, // Bits counted.
  output logic first_o // First bit.
);
  logic act_q;
  logic dat_q;
  initial
  begin
    link_clk_o = 1'b0;
    #7;
    forever #200 link_clk_o = ~link_clk_o;
  end
  always @(posedge clk_i)
  begin
    act_q <= cal_active_i;
    dat_q <= cal_data_i;
    if (cal_active_i && !act_q)
    begin
      bits_o <= 17'h00001;
      first_o <= cal_data_i;
    end
    else if (cal_active_i && cal_data_i != dat_q)
      bits_o <= bits_o + 17'h00001;
  end
endmodule
`default_nettype wire

// ===== tb/tb_cstx_calibration_status.sv
// Purpose: Self-checking bench for the calibration and status block.
// Assumes: Inputs change 2 ns after the rising clock edge.
// Notes: Only length codes 00 and 01 are run; the longer codes would exceed the run budget.
`timescale 1ns/100ps
`default_nettype none
module tb_cstx_calibration_status;
  logic clk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, tx_idle_i = 1'b0, tx_init_i = 1'b0;
  logic frame_end_sent_i = 1'b0, initial_cal_enable_i = 1'b0, sync_forwarding_i = 1'b0, streams_synced_i = 1'b0;
  logic tx_error_i = 1'b0, reg_rvalid_o, link_clk_i, cal_active_o, cal_data_o, hs_data_allowed_o, first_bit;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic [3:0] rx_enabled_i = 4'h3, rx_valid_i = 4'h0;
  logic [16:0] bits;
  int failures = 0;
  int compares = 0;
  always #25 clk_i = ~clk_i;
  cstx_calibration_status #(.RX_PORTS(4)) cstx_calibration_status_i (.clk_i, .reset_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .link_clk_i, .tx_idle_i, .frame_end_sent_i, .tx_init_i,
    .initial_cal_enable_i, .rx_enabled_i, .rx_valid_i, .sync_forwarding_i, .streams_synced_i, .tx_error_i,
    .cal_active_o, .cal_data_o, .hs_data_allowed_o);
  cstx_link_model cstx_link_model_i (.clk_i, .cal_active_i(cal_active_o), .cal_data_i(cal_data_o),
    .link_clk_o(link_clk_i), .bits_o(bits), .first_o(first_bit));
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    tick(1);
    reg_wr_i = 1'b0;
  endtask
  // Valid and data are judged together, one cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    tick(1);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    tick(1);
    reg_rd_i = 1'b0;
    chk({8'h00, reg_rvalid_o, reg_rdata_o}, {9'h001, exp});
  endtask
  task automatic wait_act(input logic lvl);
    int n;
    n = 0;
    while (cal_active_o !== lvl && n < 40000)
    begin
      tick(1);
      n++;
    end
    if (n == 40000)
    begin
      failures++;
      give_verdict();
    end
  endtask
  task automatic t_regs;
    chk(17'(hs_data_allowed_o), 17'h00000);
    rd(8'h34, 8'h00);
    rd(8'h35, 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h34, 8'h3C);
    rd(8'h34, 8'h00);
    wr(8'h32, 8'h01);
    rd(8'h32, 8'h01);
    wr(8'h34, 8'hFC);
    rd(8'h34, 8'h3C);
  endtask
  task automatic t_init;
    wr(8'h34, 8'h00);
    initial_cal_enable_i = 1'b1;
    tx_idle_i = 1'b1;
    tx_init_i = 1'b1;
    tick(1);
    tx_init_i = 1'b0;
    wait_act(1'b1);
    chk(17'(hs_data_allowed_o), 17'h00000);
    wait_act(1'b0);
    tick(2);
    chk(bits, 17'h00400);
    chk(17'(hs_data_allowed_o), 17'h00001);
    initial_cal_enable_i = 1'b0;
  endtask
  task automatic t_status;
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h34, {4'h0, k[2], 3'h0});
      rx_valid_i = {~k[1:0], k[1:0]};
      tick(4);
      rd(8'h35, {7'h00, k[2] ? k[1:0] == 2'h3 : k[1:0] != 2'h0});
    end
    for (int k = 0; k < 4; k++)
    begin
      sync_forwarding_i = k[0];
      streams_synced_i = k[1];
      tick(4);
      rd(8'h35, {6'h00, k == 3, 1'b1});
    end
    sync_forwarding_i = 1'b0;
    tx_error_i = 1'b1;
    tick(4);
    rd(8'h35, 8'h00);
    tx_error_i = 1'b0;
  endtask
  task automatic t_single(input logic [1:0] code, input logic inv, input logic [16:0] len);
    tx_idle_i = 1'b0;
    wr(8'h34, {2'h0, code, 1'b0, inv, 2'h2});
    tick(40);
    chk(17'(cal_active_o), 17'h00000);
    tx_idle_i = 1'b1;
    wait_act(1'b1);
    tick(1);
    chk(17'(first_bit), 17'(inv));
    wait_act(1'b0);
    tick(2);
    chk(bits, len);
    rd(8'h34, {2'h0, code, 1'b0, inv, 2'h0});
  endtask
  task automatic t_periodic;
    for (int k = 1; k >= 0; k--)
    begin
      wr(8'h34, {7'h00, k[0]});
      frame_end_sent_i = 1'b1;
      tick(1);
      frame_end_sent_i = 1'b0;
      tick(40);
      chk(17'(cal_active_o), 17'(k[0]));
      wait_act(1'b0);
    end
  endtask
  task automatic give_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    tick(4);
    reset_i = 1'b0;
    t_regs();
    t_init();
    t_status();
    t_single(2'h0, 1'b0, 17'h00400);
    t_single(2'h1, 1'b1, 17'h01000);
    t_periodic();
    give_verdict();
  end
endmodule
`default_nettype wire
